// [logic/xpd_addr_match.sv]
/*
 xpd_addr_match: general-purpose select match of an i/o address against a
 base and a mask of don't-care low bits.
 assumes: combinational use inside the decoder.
*/
module xpd_addr_match #(
   parameter int AW = 16,
   parameter int MW = 8
) (
   input  wire logic [AW-1:0] addr,
   input  wire logic [AW-1:0] base,
   input  wire logic [MW-1:0] mask,
   input  wire logic          enable,
   output logic               hit
);
   logic [AW-1:0] care;

   // ----------------------------------------------------------------------
   // mask bits set mean the address bit is ignored
   // ----------------------------------------------------------------------
   assign care = ~{{(AW-MW){1'b0}}, mask};
   assign hit  = enable && (((addr ^ base) & care) == '0);
endmodule // xpd_addr_match

// [logic/xpd_consts.svh]
/*
 xpd_consts.svh: port addresses, decode ranges and reset values of the
 x-bus peripheral decoder.
 assumes: included by bare name from xpd_top only; the package does not include it.
*/
`ifndef XPD_CONSTS_SVH
`define XPD_CONSTS_SVH

// ----------------------------------------------------------------------
// clock-chip ports
// ----------------------------------------------------------------------
`define XPD_RTC_INDEX_PORT  16'h0070
`define XPD_RTC_DATA_PORT   16'h0071
`define XPD_RTC_PW_LO       8'h36
`define XPD_RTC_PW_HI       8'h3F

// ----------------------------------------------------------------------
// floppy, ide, serial and parallel ranges
// ----------------------------------------------------------------------
`define XPD_FDC_PRI_LO      16'h03F0
`define XPD_FDC_PRI_HI      16'h03F7
`define XPD_FDC_SEC_LO      16'h0370
`define XPD_FDC_SEC_HI      16'h0377
`define XPD_FDC_PRI_CHG     16'h03F7
`define XPD_FDC_SEC_CHG     16'h0377
`define XPD_IDE_LO          16'h01F0
`define XPD_IDE_HI          16'h01F7
`define XPD_IDE_ALT_LO      16'h03F6
`define XPD_IDE_ALT_HI      16'h03F7
`define XPD_COM1_LO         16'h03F8
`define XPD_COM1_HI         16'h03FF
`define XPD_COM2_LO         16'h02F8
`define XPD_COM2_HI         16'h02FF
`define XPD_LPT_LO          16'h0378
`define XPD_LPT_HI          16'h037F

// ----------------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------------
`define XPD_SD7_BIT         7
`define XPD_IDX_RST         8'h00
`define XPD_GP_COUNT        3

`endif

// [logic/xpd_pkg.sv]
/*
 xpd_pkg: types of the x-bus peripheral decoder.
 assumes: compiled before every design module.
*/
package xpd_pkg;

   // codes driven on the encoded select pins
   typedef enum logic [2:0] {
      XPD_ENC_COM1 = 3'b000,
      XPD_ENC_COM2 = 3'b001,
      XPD_ENC_LPT  = 3'b010,
      XPD_ENC_IDE  = 3'b011,
      XPD_ENC_GP0  = 3'b100,
      XPD_ENC_GP1  = 3'b101,
      XPD_ENC_GP2  = 3'b110,
      XPD_ENC_IDLE = 3'b111
   } xpd_enc_t;

   // inclusive address window test
   function automatic logic xpd_in_range(input logic [15:0] a,
                                         input logic [15:0] lo,
                                         input logic [15:0] hi);
      return (a >= lo) && (a <= hi);
   endfunction

endpackage

// [logic/xpd_sync3.sv]
/*
 xpd_sync3: three-flop input synchroniser; the output follows once the
 second and third stages agree.
 assumes: input from outside the sys_clk domain.
*/
module xpd_sync3 (
   input  wire logic sys_clk,
   input  wire logic clk_en,
   input  wire logic async_in,
   output logic      sync_out
);
   logic s1_q;
   logic s2_q;
   logic s3_q;

   // ----------------------------------------------------------------------
   // chain runs through reset so a strap is valid at release
   // ----------------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (clk_en) begin
         s1_q <= async_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (clk_en && (s2_q == s3_q)) begin
         sync_out <= s3_q;
      end
   end
endmodule // xpd_sync3

// [logic/xpd_top.sv]
/*
 xpd_top: x-bus peripheral decoder: clock-chip strobes, floppy select and
 disk-change bit, activity light, configuration ram strobes, transceiver
 control and general-purpose or encoded selects.
 assumes: cycle qualifiers and address come from logic on sys_clk;
 disk_change_in comes from a pin; configuration bits are held elsewhere.
*/
// Summary of operation
// - a write to port 070h raises the clock-chip address latch strobe
// - clock-chip read strobe low during i/o reads of port 0071h
// - clock-chip write strobe low during i/o writes of port 0071h
// - password protection blocks clock-chip strobes for index 36h to 3Fh
// - floppy select low for i/o cycles in the floppy decode space
// - reads of 3F7h/377h drive inverted disk-change on bit 7 if ide off and floppy present
// - disk-change sampled at reset release; low means no floppy support
// - activity light low when port 92 bit 6 or bit 7 is set
// - configuration ram read strobe for i/o reads inside the programmed range
// - configuration ram write strobe for i/o writes inside the programmed range
// - transceiver direction high for i/o reads by any master or dma
// - direction high for bios memory cycles and dma bios i/o writes
// - direction low otherwise and through reset, independent of decode
// - buffer enable low when an enabled x-bus peripheral is decoded
// - buffer stays off: no floppy, dack2 ignored, change-bit read without ide
// - buffer enable high for disabled decode spaces and during reset
// - mode bit 4 picks general-purpose or encoded use of select pins
// - general-purpose selects match programmed base and mask registers
// - encoded mode drives a 3-bit code for an external decoder
// - mode bit zero gives general-purpose, one gives encoded selects
`include "xpd_consts.svh"
module xpd_top
   import xpd_pkg::*;
#(
   parameter int GP_N = `XPD_GP_COUNT
) (
   input  wire logic              sys_clk,
   input  wire logic              resetn,
   input  wire logic              clk_en,
   input  wire logic [15:0]       addr,
   input  wire logic [7:0]        data_in,
   input  wire logic              io_rd,
   input  wire logic              io_wr,
   input  wire logic              mem_rd,
   input  wire logic              mem_wr,
   input  wire logic              master_eisa,
   input  wire logic              master_isa,
   input  wire logic              master_dma,
   input  wire logic              bios_decoded,
   input  wire logic              dma_bios_sel,
   input  wire logic              disk_change_in,
   input  wire logic              pw_protect,
   input  wire logic              disk_light_b6,
   input  wire logic              disk_light_b7,
   input  wire logic              mode_encoded,
   input  wire logic              floppy_en,
   input  wire logic              floppy_secondary,
   input  wire logic              ide_en,
   input  wire logic              com1_en,
   input  wire logic              com2_en,
   input  wire logic              lpt_en,
   input  wire logic              dor_ignore_dack2,
   input  wire logic [15:0]       cram_lo_addr,
   input  wire logic [15:0]       cram_hi_addr,
   input  wire logic [GP_N*16-1:0] gp_base,
   input  wire logic [GP_N*8-1:0] gp_mask,
   input  wire logic [GP_N-1:0]   gp_en,
   output logic                   clockchip_addr_latch,
   output logic                   clockchip_read_n,
   output logic                   clockchip_write_n,
   output logic                   floppy_select_n,
   output logic                   sd7_out,
   output logic                   sd7_oe,
   output logic                   disk_activity_led_n,
   output logic                   cfg_ram_read_n,
   output logic                   cfg_ram_write_n,
   output logic                   xbuf_direction,
   output logic                   xbuf_output_enable_n,
   output logic [GP_N-1:0]        gp_select_n,
   output logic [2:0]             encoded_select,
   output logic                   ide_select_n,
   output logic                   floppy_present
);

   // ----------------------------------------------------------------------
   // disk-change synchroniser and presence strap
   // ----------------------------------------------------------------------
   logic dchg_sync;
   logic rst_done_q;
   logic present_q;

   xpd_sync3 u_dchg_sync (
      .sys_clk  (sys_clk),
      .clk_en   (clk_en),
      .async_in (disk_change_in),
      .sync_out (dchg_sync)
   );

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         rst_done_q <= 1'b0;
         present_q  <= 1'b0;
      end else if (clk_en && !rst_done_q) begin
         rst_done_q <= 1'b1;
         present_q  <= dchg_sync;
      end
   end
   assign floppy_present = present_q;

   // ----------------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------------
   logic io_cyc;
   logic hit_idx;
   logic hit_dat;
   logic hit_fdc;
   logic hit_chg;
   logic hit_ide;
   logic hit_com1;
   logic hit_com2;
   logic hit_lpt;
   logic hit_cram;
   logic pw_block;
   logic [GP_N-1:0] hit_gp;
   logic [7:0] rtc_index_q;

   assign io_cyc  = io_rd || io_wr;
   assign hit_idx = (addr == `XPD_RTC_INDEX_PORT);
   assign hit_dat = (addr == `XPD_RTC_DATA_PORT);
   assign hit_fdc = floppy_en && (floppy_secondary ?
                    xpd_in_range(addr, `XPD_FDC_SEC_LO, `XPD_FDC_SEC_HI) :
                    xpd_in_range(addr, `XPD_FDC_PRI_LO, `XPD_FDC_PRI_HI));
   assign hit_chg = floppy_en && (floppy_secondary ? (addr == `XPD_FDC_SEC_CHG) :
                                                     (addr == `XPD_FDC_PRI_CHG));
   assign hit_ide = ide_en && (xpd_in_range(addr, `XPD_IDE_LO, `XPD_IDE_HI) ||
                    xpd_in_range(addr, `XPD_IDE_ALT_LO, `XPD_IDE_ALT_HI));
   assign hit_com1 = com1_en && xpd_in_range(addr, `XPD_COM1_LO, `XPD_COM1_HI);
   assign hit_com2 = com2_en && xpd_in_range(addr, `XPD_COM2_LO, `XPD_COM2_HI);
   assign hit_lpt  = lpt_en && xpd_in_range(addr, `XPD_LPT_LO, `XPD_LPT_HI);
   assign hit_cram = xpd_in_range(addr, cram_lo_addr, cram_hi_addr);
   assign pw_block = pw_protect && (rtc_index_q >= `XPD_RTC_PW_LO)
                     && (rtc_index_q <= `XPD_RTC_PW_HI);

   for (genvar g = 0; g < GP_N; g++) begin : g_gp
      xpd_addr_match #(.AW(16), .MW(8)) u_match (
         .addr   (addr),
         .base   (gp_base[g*16 +: 16]),
         .mask   (gp_mask[g*8 +: 8]),
         .enable (gp_en[g]),
         .hit    (hit_gp[g])
      );
   end

   // ----------------------------------------------------------------------
   // clock-chip index latch and address latch pulse
   // ----------------------------------------------------------------------
   logic io_wr_q;
   logic ale_d;

   assign ale_d = io_wr && !io_wr_q && hit_idx;

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         io_wr_q              <= 1'b0;
         rtc_index_q          <= `XPD_IDX_RST;
         clockchip_addr_latch <= 1'b0;
      end else if (clk_en) begin
         io_wr_q              <= io_wr;
         clockchip_addr_latch <= ale_d;
         if (ale_d) begin
            rtc_index_q <= data_in;
         end
      end
   end

   // ----------------------------------------------------------------------
   // command strobes
   // ----------------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         clockchip_read_n  <= 1'b1;
         clockchip_write_n <= 1'b1;
         cfg_ram_read_n    <= 1'b1;
         cfg_ram_write_n   <= 1'b1;
         floppy_select_n   <= 1'b1;
      end else if (clk_en) begin
         clockchip_read_n  <= !(io_rd && hit_dat && !pw_block);
         clockchip_write_n <= !(io_wr && hit_dat && !pw_block);
         cfg_ram_read_n    <= !(io_rd && hit_cram);
         cfg_ram_write_n   <= !(io_wr && hit_cram);
         floppy_select_n   <= !(io_cyc && hit_fdc);
      end
   end

   // ----------------------------------------------------------------------
   // disk-change bit and activity light
   // ----------------------------------------------------------------------
   logic chg_read;
   assign chg_read = io_rd && hit_chg;

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         sd7_out             <= 1'b0;
         sd7_oe              <= 1'b0;
         disk_activity_led_n <= 1'b1;
      end else if (clk_en) begin
         sd7_out             <= !dchg_sync;
         sd7_oe              <= chg_read && !ide_en && present_q;
         disk_activity_led_n <= !(disk_light_b6 || disk_light_b7);
      end
   end

   // ----------------------------------------------------------------------
   // transceiver direction and output enable
   // ----------------------------------------------------------------------
   logic dir_d;
   logic fdc_buf_ok;
   logic oe_d;

   assign dir_d = (io_rd && (master_eisa || master_isa || master_dma))
                  || ((mem_rd || mem_wr) && bios_decoded)
                  || (master_dma && io_wr && dma_bios_sel);

   assign fdc_buf_ok = hit_fdc && present_q && !dor_ignore_dack2
                       && !(chg_read && !ide_en);
   assign oe_d = (io_cyc && (hit_idx || hit_dat || fdc_buf_ok || hit_ide
                  || hit_com1 || hit_com2 || hit_lpt || hit_cram
                  || (|hit_gp)))
                 || ((mem_rd || mem_wr) && bios_decoded);

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         xbuf_direction       <= 1'b0;
         xbuf_output_enable_n <= 1'b1;
      end else if (clk_en) begin
         xbuf_direction       <= dir_d;
         xbuf_output_enable_n <= !oe_d;
      end
   end

   // ----------------------------------------------------------------------
   // general-purpose or encoded selects
   // ----------------------------------------------------------------------
   xpd_enc_t enc_d;

   always_comb begin
      enc_d = XPD_ENC_IDLE;
      if (io_cyc) begin
         if (hit_com1) begin
            enc_d = XPD_ENC_COM1;
         end else if (hit_com2) begin
            enc_d = XPD_ENC_COM2;
         end else if (hit_lpt) begin
            enc_d = XPD_ENC_LPT;
         end else if (hit_ide) begin
            enc_d = XPD_ENC_IDE;
         end else if (hit_gp[0]) begin
            enc_d = XPD_ENC_GP0;
         end else if (GP_N > 1 && hit_gp[GP_N > 1 ? 1 : 0]) begin
            enc_d = XPD_ENC_GP1;
         end else if (GP_N > 2 && hit_gp[GP_N > 2 ? 2 : 0]) begin
            enc_d = XPD_ENC_GP2;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         gp_select_n    <= '1;
         encoded_select <= XPD_ENC_IDLE;
         ide_select_n   <= 1'b1;
      end else if (clk_en) begin
         ide_select_n <= !(io_cyc && hit_ide);
         if (mode_encoded) begin
            gp_select_n    <= '1;
            encoded_select <= enc_d;
         end else begin
            gp_select_n    <= ~(hit_gp & {GP_N{io_cyc}});
            encoded_select <= XPD_ENC_IDLE;
         end
      end
   end

   // ----------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------
   chk_ale_pulse: assert property (@(posedge sys_clk) disable iff (!resetn)
      clockchip_addr_latch && clk_en |=> !clockchip_addr_latch)
      else $error("address latch pulse longer than one clock");

   chk_ale_cause: assert property (@(posedge sys_clk) disable iff (!resetn)
      clk_en && io_wr && !io_wr_q && hit_idx |=> clockchip_addr_latch)
      else $error("index write gave no address latch pulse");

   chk_rtc_read: assert property (@(posedge sys_clk) disable iff (!resetn)
      clk_en && io_rd && hit_dat && !pw_block |=> !clockchip_read_n)
      else $error("clock-chip read strobe missing");

   chk_rtc_write: assert property (@(posedge sys_clk) disable iff (!resetn)
      clk_en && io_wr && hit_dat && !pw_block |=> !clockchip_write_n)
      else $error("clock-chip write strobe missing");

   chk_pw_block: assert property (@(posedge sys_clk) disable iff (!resetn)
      clk_en && pw_protect && rtc_index_q[7:4] == 4'h3 && rtc_index_q[3:0] >= 4'h6
      |=> clockchip_read_n && clockchip_write_n)
      else $error("protected clock-chip index was reached");

   chk_fdc_sel: assert property (@(posedge sys_clk) disable iff (!resetn)
      clk_en && io_cyc && hit_fdc |=> !floppy_select_n)
      else $error("floppy select missing");

   chk_sd7_gate: assert property (@(posedge sys_clk) disable iff (!resetn)
      sd7_oe && $past(clk_en) |-> present_q && !$past(ide_en))
      else $error("bit 7 driven without floppy or with ide on");

   chk_led_map: assert property (@(posedge sys_clk) disable iff (!resetn)
      clk_en && !disk_light_b6 && !disk_light_b7 |=> disk_activity_led_n)
      else $error("activity light on with both bits clear");

   chk_cram_rd: assert property (@(posedge sys_clk) disable iff (!resetn)
      clk_en && io_rd && hit_cram |=> !cfg_ram_read_n)
      else $error("configuration ram read strobe missing");

   chk_dir_read: assert property (@(posedge sys_clk) disable iff (!resetn)
      clk_en && io_rd && master_isa |=> xbuf_direction)
      else $error("transceiver not transmitting on isa read");

   chk_oe_nofdc: assert property (@(posedge sys_clk) disable iff (!resetn)
      clk_en && io_cyc && hit_fdc && !present_q && !(hit_idx || hit_dat || hit_ide
      || hit_com1 || hit_com2 || hit_lpt || hit_cram || (|hit_gp) || bios_decoded)
      |=> xbuf_output_enable_n)
      else $error("buffer enabled for absent floppy");

   chk_enc_mode: assert property (@(posedge sys_clk) disable iff (!resetn)
      clk_en && mode_encoded |=> gp_select_n == '1)
      else $error("general-purpose select active in encoded mode");

endmodule // xpd_top

// [test/tb.sv]
/*
 tb: self-checking bench of xpd_top with the x-bus far-side model.
 assumes: xpd_pkg compiled first; outputs registered, one cycle latency.
*/
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin err_count++; \
   $display("Error %s expected %0h seen %0h", n, e, g); end end
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import xpd_pkg::*;

   logic        sys_clk, resetn, clk_en, io_rd, io_wr, mem_rd, mem_wr;
   logic        master_eisa, master_isa, master_dma, bios_decoded, dma_bios_sel;
   logic        pw_protect, disk_light_b6, disk_light_b7, mode_encoded, floppy_en;
   logic        floppy_secondary, ide_en, com1_en, com2_en, lpt_en, dor_ignore_dack2;
   logic [15:0] addr, cram_lo_addr, cram_hi_addr;
   logic [7:0]  data_in, dev_select_n;
   logic [47:0] gp_base;
   logic [23:0] gp_mask;
   logic [2:0]  gp_en, gp_select_n, encoded_select;
   logic        clockchip_addr_latch, clockchip_read_n, clockchip_write_n;
   logic        floppy_select_n, sd7_out, sd7_oe, disk_activity_led_n;
   logic        cfg_ram_read_n, cfg_ram_write_n, xbuf_direction, xbuf_output_enable_n;
   logic        ide_select_n, floppy_present, disk_change_in, present, media_changed;
   int          err_count, samples_checked, cyc, lat_cnt;
   logic [15:0] ea [5] = '{16'h03F8, 16'h02F8, 16'h0378, 16'h01F0, 16'h0302};
   logic [2:0]  ec [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4};
   logic [15:0] ca [4] = '{16'h0BFF, 16'h0C00, 16'h0C0F, 16'h0C10};
   logic [7:0]  pi [4] = '{8'h35, 8'h36, 8'h3F, 8'h40};

   xpd_top #(.GP_N(3)) i_xpd_top (.sys_clk, .resetn, .clk_en, .addr, .data_in, .io_rd,
      .io_wr, .mem_rd, .mem_wr, .master_eisa, .master_isa, .master_dma, .bios_decoded,
      .dma_bios_sel, .disk_change_in, .pw_protect, .disk_light_b6, .disk_light_b7,
      .mode_encoded, .floppy_en, .floppy_secondary, .ide_en, .com1_en, .com2_en,
      .lpt_en, .dor_ignore_dack2, .cram_lo_addr, .cram_hi_addr, .gp_base, .gp_mask,
      .gp_en, .clockchip_addr_latch, .clockchip_read_n, .clockchip_write_n,
      .floppy_select_n, .sd7_out, .sd7_oe, .disk_activity_led_n, .cfg_ram_read_n,
      .cfg_ram_write_n, .xbuf_direction, .xbuf_output_enable_n, .gp_select_n,
      .encoded_select, .ide_select_n, .floppy_present);
   xpd_xbus_model i_xpd_xbus_model (.present, .media_changed, .encoded_select,
      .disk_change_in, .dev_select_n);

   // ------------------------------------------------------------------
   // clock, watchdog and tasks
   // ------------------------------------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cyc++;
      if (clockchip_addr_latch === 1'b1) lat_cnt++;
      if (cyc == 3000) begin
         err_count++;
         complete_run();
      end
   end
   task automatic complete_run();
      $display("Compared %0d, errors %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic acc(input logic rd, input logic wr, input logic [15:0] a,
                      input logic [7:0] d);
      @(posedge sys_clk);
      io_rd <= rd;
      io_wr <= wr;
      addr <= a;
      data_in <= d;
      repeat (3) @(posedge sys_clk);
      #1;
   endtask
   task automatic idle();
      @(posedge sys_clk);
      io_rd <= 1'b0;
      io_wr <= 1'b0;
      repeat (2) @(posedge sys_clk);
      #1;
   endtask
   task automatic rst();
      @(posedge sys_clk);
      resetn <= 1'b0;
      repeat (6) @(posedge sys_clk);
      #1;
      `CHK("latch", 1'b0, clockchip_addr_latch)
      `CHK("dir", 1'b0, xbuf_direction)
      `CHK("oe_n", 1'b1, xbuf_output_enable_n)
      @(posedge sys_clk);
      resetn <= 1'b1;
      repeat (2) @(posedge sys_clk);
      #1;
      `CHK("present", present, floppy_present)
   endtask

   // ------------------------------------------------------------------
   // test sequence
   // ------------------------------------------------------------------
   initial begin
      {resetn, io_rd, io_wr, mem_rd, mem_wr, master_eisa, master_dma, bios_decoded,
       dma_bios_sel, pw_protect, disk_light_b6, disk_light_b7, mode_encoded, floppy_en,
       floppy_secondary, ide_en, com1_en, com2_en, lpt_en, dor_ignore_dack2,
       media_changed} = '0;
      {clk_en, master_isa, present} = 3'h7;
      {addr, data_in, cram_lo_addr, cram_hi_addr} = {16'h0000, 8'h00, 16'h0C00, 16'h0C0F};
      {gp_base, gp_mask, gp_en} = {48'h000000000300, 24'h000003, 3'h1};
      rst();
      for (int i = 0; i < 4; i++) begin
         @(posedge sys_clk);
         {disk_light_b7, disk_light_b6} <= i[1:0];
         repeat (3) @(posedge sys_clk);
         #1;
         `CHK("led_n", i == 0, disk_activity_led_n)
      end
      clk_en <= 1'b0;
      {disk_light_b7, disk_light_b6} <= 2'h0;
      repeat (3) @(posedge sys_clk);
      #1;
      `CHK("led_hold", 1'b0, disk_activity_led_n)
      clk_en <= 1'b1;
      repeat (3) @(posedge sys_clk);
      #1;
      `CHK("led_n", 1'b1, disk_activity_led_n)
      lat_cnt = 0;
      acc(1'b0, 1'b1, 16'h0070, 8'h0A);
      `CHK("oe_n", 1'b0, xbuf_output_enable_n)
      idle();
      `CHK("pulses", 1, lat_cnt)
      for (int i = 0; i < 3; i++) begin
         {master_eisa, master_isa, master_dma} <= 3'h4 >> i;
         acc(1'b1, 1'b0, 16'h0071, 8'h00);
         `CHK("rd_n", 1'b0, clockchip_read_n)
         `CHK("dir", 1'b1, xbuf_direction)
         idle();
      end
      acc(1'b0, 1'b1, 16'h0071, 8'h00);
      `CHK("wr_n", 1'b0, clockchip_write_n)
      `CHK("dir", 1'b0, xbuf_direction)
      idle();
      pw_protect <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         acc(1'b0, 1'b1, 16'h0070, pi[i]);
         idle();
         acc(1'b1, 1'b0, 16'h0071, 8'h00);
         `CHK("rd_n", i == 1 || i == 2, clockchip_read_n)
         idle();
         acc(1'b0, 1'b1, 16'h0071, 8'h00);
         `CHK("wr_n", i == 1 || i == 2, clockchip_write_n)
         idle();
      end
      {pw_protect, floppy_en} <= 2'h1;
      for (int i = 0; i < 2; i++) begin
         {floppy_secondary, media_changed} <= {2{i[0]}};
         repeat (6) @(posedge sys_clk);
         acc(1'b1, 1'b0, i ? 16'h0377 : 16'h03F7, 8'h00);
         `CHK("sd7_oe", 1'b1, sd7_oe)
         `CHK("sd7", i[0], sd7_out)
         `CHK("fsel_n", 1'b0, floppy_select_n)
         `CHK("oe_n", 1'b1, xbuf_output_enable_n)
         idle();
      end
      {floppy_secondary, ide_en} <= 2'h1;
      acc(1'b1, 1'b0, 16'h03F7, 8'h00);
      `CHK("sd7_oe", 1'b0, sd7_oe)
      `CHK("oe_n", 1'b0, xbuf_output_enable_n)
      idle();
      {ide_en, dor_ignore_dack2} <= 2'h1;
      acc(1'b1, 1'b0, 16'h03F0, 8'h00);
      `CHK("oe_n", 1'b1, xbuf_output_enable_n)
      idle();
      {dor_ignore_dack2, floppy_en} <= 2'h0;
      acc(1'b1, 1'b0, 16'h03F0, 8'h00);
      `CHK("fsel_n", 1'b1, floppy_select_n)
      `CHK("oe_n", 1'b1, xbuf_output_enable_n)
      idle();
      for (int i = 0; i < 8; i++) begin
         acc(!i[0], i[0], ca[i / 2], 8'h00);
         if (i[0]) `CHK("cw_n", i < 2 || i > 5, cfg_ram_write_n)
         else `CHK("cr_n", i < 2 || i > 5, cfg_ram_read_n)
         idle();
      end
      {master_isa, mem_rd, bios_decoded} <= 3'h3;
      repeat (4) @(posedge sys_clk);
      #1;
      `CHK("dir", 1'b1, xbuf_direction)
      {mem_rd, bios_decoded, master_dma, dma_bios_sel} <= 4'h3;
      acc(1'b0, 1'b1, 16'h0000, 8'h00);
      `CHK("dir", 1'b1, xbuf_direction)
      idle();
      {dma_bios_sel, master_dma, master_isa} <= 3'h1;
      acc(1'b0, 1'b1, 16'h0000, 8'h00);
      `CHK("dir", 1'b0, xbuf_direction)
      idle();
      for (int i = 0; i < 2; i++) begin
         acc(1'b1, 1'b0, i ? 16'h0304 : 16'h0302, 8'h00);
         `CHK("gp_n", i ? 3'h7 : 3'h6, gp_select_n)
         idle();
      end
      {mode_encoded, com1_en, com2_en, lpt_en, ide_en} <= 5'h1F;
      for (int i = 0; i < 5; i++) begin
         acc(1'b1, 1'b0, ea[i], 8'h00);
         `CHK("code", ec[i], encoded_select)
         `CHK("dev_n", ~(8'h01 << ec[i]), dev_select_n)
         `CHK("ide_n", i != 3, ide_select_n)
         idle();
      end
      `CHK("code", 3'h7, encoded_select)
      {present, ide_en} <= 2'h0;
      rst();
      floppy_en <= 1'b1;
      acc(1'b1, 1'b0, 16'h03F7, 8'h00);
      `CHK("sd7_oe", 1'b0, sd7_oe)
      idle();
      acc(1'b1, 1'b0, 16'h03F0, 8'h00);
      `CHK("oe_n", 1'b1, xbuf_output_enable_n)
      `CHK("fsel_n", 1'b0, floppy_select_n)
      idle();
      complete_run();
   end
endmodule // tb

// [test/xpd_xbus_model.sv]
/*
 xpd_xbus_model: far side of the decoder: floppy disk-change line with its
 board strap, and the board decoder of the encoded select code.
 assumes: the bench sets presence and media change; sel code from xpd_top.
*/
module xpd_xbus_model (
   input  wire logic       present,
   input  wire logic       media_changed,
   input  wire logic [2:0] encoded_select,
   output logic            disk_change_in,
   output logic [7:0]      dev_select_n
);
   timeunit 1ns;
   timeprecision 1ps;

   // ------------------------------------------------------------------
   // floppy line and select decoder
   // ------------------------------------------------------------------
   // strapped low when no floppy, else low once media changed
   assign disk_change_in = present & ~media_changed;
   // three-to-eight decoder, one active-low output per code
   assign dev_select_n = ~(8'h01 << encoded_select);
endmodule // xpd_xbus_model
